// ===== core/asp_pkg.sv
// constants, register map and state types of the asynchronous serial port
// Notes on behaviour
// - 10-bit frame: start, eight data LSB-first, stop
// - timer overflows set rate; doubling flag doubles it on port 0 only
// - buffer write starts frame; done flag at stop
// - enabled receiver starts on falling receive edge
// - 10-bit accept: done clear, address and stop checked
// - accepted 10-bit frame loads byte, stop, done flag
// - after frame check, watch again for falling edge
// - 11-bit frame adds programmable ninth bit before stop
// - fixed 11-bit mode runs system clock /64 or /32
// - transmit ninth bit sent after data, before stop
// - 11-bit accept uses ninth bit; ninth bit stored
// - timer 11-bit mode equals fixed mode, timer clocked
// - port 0 source select: 0 timer 1, 1 timer 3
// - port 1 clocked from timer 3 in all but the fixed 11-bit mode
// - timer 1 reload byte, divide by twelve, over 32
// - timer 1 clock select drops the divide by twelve
// - timer 3 prescaled 16-bit reload; port 1 over 16
// - data buffer: writes transmit, reads receive register
// - sticky framing error flag, cleared only by software
// - given address is address AND mask
package asp_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_DATA = 8'h04;
  localparam logic [7:0] ADR_MISC = 8'h08;
  localparam logic [7:0] ADR_T1RL = 8'h0c;
  localparam logic [7:0] ADR_T3RL = 8'h10;
  localparam logic [7:0] ADR_T3RH = 8'h14;
  localparam logic [7:0] ADR_SLAVE_ADDRESS_REG = 8'h18;
  localparam logic [7:0] ADR_SLAVE_ADDRESS_MASK = 8'h1c;
  localparam logic [7:0] ADR_TIMER3_AND_SERIAL_RATE_CONTROL = 8'hc4;
  // control register fields
  localparam int CTL_RI = 0;
  localparam int CTL_TI = 1;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TB8 = 3;
  localparam int CTL_REN = 4;
  localparam int CTL_SM2 = 5;
  localparam int CTL_SML = 6;
  localparam int CTL_SMH = 7;
  // misc register fields
  localparam int MSC_RATE_DOUBLING_FLAG = 0;
  localparam int MSC_T1M = 1;
  localparam int MSC_FE = 2;
  localparam int MSC_T1RUN = 3;
  // timer 3 control fields
  localparam int T3_SMOD1 = 7;
  localparam int T3_ERRACC = 6;
  localparam int T3_BAUD_SOURCE_SELECT = 5;
  localparam int T3_TF3 = 4;
  localparam int T3_TR3 = 3;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_TIMER3_AND_SERIAL_RATE_CONTROL = 8'h00;
  // timing counts
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] T1_PRE_LAST = 4'hb;
  localparam logic [1:0] FIX_LAST_SLOW = 2'h3;
  localparam logic [1:0] FIX_LAST_FAST = 2'h1;
  localparam logic [3:0] BITS_10 = 4'ha;
  localparam logic [3:0] BITS_11 = 4'hb;
  // receiver and transmitter states
  typedef enum logic [2:0] {
    R_IDLE = 3'b000,
    R_START = 3'b001,
    R_DATA = 3'b010,
    R_NINTH = 3'b011,
    R_STOP = 3'b100
  } asp_rx_e;
  typedef enum logic [0:0] {
    T_IDLE = 1'b0,
    T_SEND = 1'b1
  } asp_tx_e;
endpackage

// ===== core/asp_baud.sv
// baud tick generator: timer 1, timer 3 and the fixed system-clock divider
`timescale 1ns/1ns
`default_nettype none
module asp_baud
  import asp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // rate selection
  input wire logic i_fixed_mode,
  input wire logic i_dbl,
  input wire logic i_div16,
  input wire logic i_t3_sel,
  // timer 1 setup
  input wire logic i_t1_run,
  input wire logic i_t1_fast,
  input wire logic [7:0] i_t1_reload,
  // timer 3 setup
  input wire logic i_t3_run,
  input wire logic [2:0] i_t3_ps,
  input wire logic [15:0] i_t3_reload,
  // ticks
  output logic o_tick,
  output logic o_t3_ovf
);
  typedef struct packed {
    logic [3:0] t1_pre;
    logic [7:0] t1_cnt;
    logic [6:0] t3_pre;
    logic [15:0] t3_cnt;
    logic half;
    logic [1:0] fix_cnt;
    logic tick;
    logic t3_ovf;
  } asp_baud_s;
  asp_baud_s st;
  asp_baud_s next_st;
  logic t1_step;
  logic t1_ovf;
  logic t3_step;
  logic t3_ovf;
  logic ovf;
  logic [6:0] mask;

  // one tick per sixteenth of a bit, whatever the source
  always_comb begin
    next_st = st;
    t1_step = i_t1_run && (i_t1_fast || st.t1_pre == T1_PRE_LAST);
    next_st.t1_pre = t1_step || !i_t1_run ? 4'h0 : st.t1_pre + 4'h1;
    t1_ovf = t1_step && st.t1_cnt == 8'hff;
    if (t1_step) begin
      next_st.t1_cnt = t1_ovf ? i_t1_reload : st.t1_cnt + 8'h01;
    end
    mask = 7'((8'h01 << i_t3_ps) - 8'h01);
    t3_step = i_t3_run && (st.t3_pre & mask) == mask;
    next_st.t3_pre = i_t3_run ? st.t3_pre + 7'h01 : 7'h00;
    t3_ovf = t3_step && st.t3_cnt == 16'hffff;
    if (t3_step) begin
      next_st.t3_cnt = t3_ovf ? i_t3_reload : st.t3_cnt + 16'h0001;
    end
    ovf = i_t3_sel ? t3_ovf : t1_ovf;
    if (ovf) begin
      next_st.half = ~st.half;
    end
    // fixed divider free runs; only its wrap is used in the fixed mode
    next_st.fix_cnt = st.fix_cnt == (i_dbl ? FIX_LAST_FAST : FIX_LAST_SLOW) ? 2'h0
                      : st.fix_cnt + 2'h1;
    if (i_fixed_mode) begin
      next_st.tick = st.fix_cnt == (i_dbl ? FIX_LAST_FAST : FIX_LAST_SLOW);
    end else begin
      // halving the overflow rate gives the over-32 form; doubling drops it
      next_st.tick = ovf && (i_dbl || i_div16 || st.half);
    end
    next_st.t3_ovf = t3_ovf;
  end

  // state register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;
  assign o_t3_ovf = st.t3_ovf;
endmodule // asp_baud
`default_nettype wire

// ===== core/asp_uart.sv
// asynchronous serial port, 10-bit and 11-bit modes, behind a wishbone slave
`timescale 1ns/1ns
`default_nettype none
module asp_uart
  import asp_pkg::*;
#(
  parameter bit IS_PORT1 = 1'b0
)
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // serial lines
  input wire logic I_RXD,
  output logic O_TXD
);
  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [7:0] ctrl;
    logic [7:0] misc;
    logic [7:0] rxbuf;
    logic [7:0] t1rl;
    logic [7:0] t3rl;
    logic [7:0] t3rh;
    logic [7:0] slave_address_reg;
    logic [7:0] slave_address_mask;
    logic [7:0] timer3_and_serial_rate_control;
    logic rx_s1;
    logic rx_s2;
    logic rx_prev;
    asp_rx_e rstate;
    logic [3:0] rcnt;
    logic [3:0] rbits;
    logic [8:0] rshift;
    asp_tx_e tstate;
    logic [3:0] tcnt;
    logic [3:0] tbits;
    logic [10:0] tshift;
    logic txd;
  } asp_state_s;
  asp_state_s st;
  asp_state_s next_st;

  logic tick;
  logic t3_ovf;
  logic acc;
  logic wr;
  logic is11;
  logic fixed_mode;
  logic mode_on;
  logic dbl;
  logic t3_sel;
  logic baud_run;
  logic rx;
  logic ninth;
  logic accept_now;

  // address hit: given is address AND mask, broadcast is address OR mask
  function automatic logic addr_hit(input logic [7:0] d, input logic [7:0] a,
                                    input logic [7:0] m);
    logic given_ok;
    logic bcast_ok;
    given_ok = ((d ^ a) & m) == 8'h00;
    bcast_ok = ((d ^ (a | m)) & (a | m)) == 8'h00;
    return given_ok || bcast_ok;
  endfunction

  // mode decode and bus strobes
  assign acc = I_WB_CYC && I_WB_STB;
  assign wr = acc && st.ack && I_WB_WE && I_WB_SEL[0];
  assign is11 = st.ctrl[CTL_SMH];
  assign fixed_mode = st.ctrl[CTL_SMH] && !st.ctrl[CTL_SML];
  assign mode_on = st.ctrl[CTL_SMH] || st.ctrl[CTL_SML];
  assign dbl = IS_PORT1 ? st.timer3_and_serial_rate_control[T3_SMOD1] : st.misc[MSC_RATE_DOUBLING_FLAG];
  assign t3_sel = IS_PORT1 || st.timer3_and_serial_rate_control[T3_BAUD_SOURCE_SELECT];
  assign baud_run = fixed_mode || (t3_sel ? st.timer3_and_serial_rate_control[T3_TR3] : st.misc[MSC_T1RUN]);
  assign rx = st.rx_s2;
  // the ninth bit is the stop bit in the 10-bit mode
  assign ninth = is11 ? st.rshift[8] : rx;
  assign accept_now = !st.ctrl[CTL_RI] && (!st.ctrl[CTL_SM2]
                      || (ninth && addr_hit(st.rshift[7:0], st.slave_address_reg, st.slave_address_mask)));

  // baud tick source
  asp_baud u_baud (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_fixed_mode(fixed_mode),
    .i_dbl(dbl),
    .i_div16(IS_PORT1),
    .i_t3_sel(t3_sel),
    .i_t1_run(st.misc[MSC_T1RUN]),
    .i_t1_fast(st.misc[MSC_T1M]),
    .i_t1_reload(st.t1rl),
    .i_t3_run(st.timer3_and_serial_rate_control[T3_TR3]),
    .i_t3_ps(st.timer3_and_serial_rate_control[2:0]),
    .i_t3_reload({st.t3rh, st.t3rl}),
    .o_tick(tick),
    .o_t3_ovf(t3_ovf)
  );

  // whole next state: bus first, hardware events last so a set beats a clear
  always_comb begin
    next_st = st;
    next_st.rx_s1 = I_RXD;
    next_st.rx_s2 = st.rx_s1;
    next_st.rx_prev = st.rx_s2;
    // registered ack, high for one cycle per request
    next_st.ack = acc && !st.ack;
    if (acc && !st.ack) begin
      unique case (I_WB_ADR)
        ADR_CTRL: next_st.rdat = st.ctrl;
        ADR_DATA: next_st.rdat = st.rxbuf;
        ADR_MISC: next_st.rdat = st.misc;
        ADR_T1RL: next_st.rdat = st.t1rl;
        ADR_T3RL: next_st.rdat = st.t3rl;
        ADR_T3RH: next_st.rdat = st.t3rh;
        ADR_SLAVE_ADDRESS_REG: next_st.rdat = st.slave_address_reg;
        ADR_SLAVE_ADDRESS_MASK: next_st.rdat = st.slave_address_mask;
        ADR_TIMER3_AND_SERIAL_RATE_CONTROL: next_st.rdat = st.timer3_and_serial_rate_control;
        default: next_st.rdat = 8'h00;
      endcase
    end
    if (wr) begin
      unique case (I_WB_ADR)
        ADR_CTRL: next_st.ctrl = I_WB_DAT[7:0];
        ADR_MISC: next_st.misc = I_WB_DAT[7:0];
        ADR_T1RL: next_st.t1rl = I_WB_DAT[7:0];
        ADR_T3RL: next_st.t3rl = I_WB_DAT[7:0];
        ADR_T3RH: next_st.t3rh = I_WB_DAT[7:0];
        ADR_SLAVE_ADDRESS_REG: next_st.slave_address_reg = I_WB_DAT[7:0];
        ADR_SLAVE_ADDRESS_MASK: next_st.slave_address_mask = I_WB_DAT[7:0];
        ADR_TIMER3_AND_SERIAL_RATE_CONTROL: next_st.timer3_and_serial_rate_control = I_WB_DAT[7:0];
        default: ;
      endcase
    end
    // transmitter: a write to the data buffer (re)starts a frame
    if (st.tstate == T_SEND && tick) begin
      next_st.tcnt = st.tcnt + 4'h1;
      if (st.tcnt == OVS_LAST) begin
        if (st.tbits == 4'h1) begin
          next_st.tstate = T_IDLE;
          next_st.txd = 1'b1;
        end else begin
          next_st.txd = st.tshift[1];
          next_st.tshift = {1'b1, st.tshift[10:1]};
          next_st.tbits = st.tbits - 4'h1;
          if (st.tbits == 4'h2) begin
            next_st.ctrl[CTL_TI] = 1'b1;
          end
        end
      end
    end
    if (wr && I_WB_ADR == ADR_DATA && mode_on) begin
      next_st.tstate = T_SEND;
      next_st.tcnt = 4'h0;
      next_st.txd = 1'b0;
      next_st.tbits = is11 ? BITS_11 : BITS_10;
      next_st.tshift = {1'b1, is11 ? next_st.ctrl[CTL_TB8] : 1'b1, I_WB_DAT[7:0], 1'b0};
    end
    // receiver, sampling each bit at its sixteenth-tick centre
    if (st.rstate != R_IDLE && tick) begin
      next_st.rcnt = st.rcnt + 4'h1;
    end
    unique case (st.rstate)
      R_IDLE: begin
        if (st.ctrl[CTL_REN] && mode_on && baud_run && st.rx_prev && !rx) begin
          next_st.rstate = R_START;
          next_st.rcnt = 4'h0;
        end
      end
      R_START: begin
        if (tick && st.rcnt == OVS_MID) begin
          next_st.rcnt = 4'h0;
          next_st.rbits = 4'h0;
          // a high start midpoint is noise, not a frame
          next_st.rstate = rx ? R_IDLE : R_DATA;
        end
      end
      R_DATA: begin
        if (tick && st.rcnt == OVS_LAST) begin
          next_st.rshift[7:0] = {rx, st.rshift[7:1]};
          next_st.rbits = st.rbits + 4'h1;
          if (st.rbits == 4'h7) begin
            next_st.rstate = is11 ? R_NINTH : R_STOP;
          end
        end
      end
      R_NINTH: begin
        if (tick && st.rcnt == OVS_LAST) begin
          next_st.rshift[8] = rx;
          next_st.rstate = R_STOP;
        end
      end
      R_STOP: begin
        if (tick && st.rcnt == OVS_LAST) begin
          next_st.rstate = R_IDLE;
          if (!rx) begin
            next_st.misc[MSC_FE] = 1'b1;
          end
          if (accept_now) begin
            next_st.rxbuf = st.rshift[7:0];
            next_st.ctrl[CTL_RB8] = ninth;
            next_st.ctrl[CTL_RI] = 1'b1;
          end
        end
      end
      default: next_st.rstate = R_IDLE;
    endcase
    if (t3_ovf) begin
      next_st.timer3_and_serial_rate_control[T3_TF3] = 1'b1;
    end
  end

  // state register
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      st <= '0;
      st.ctrl <= RST_REG;
      st.misc <= RST_REG;
      st.timer3_and_serial_rate_control <= RST_TIMER3_AND_SERIAL_RATE_CONTROL;
      st.rx_s1 <= 1'b1;
      st.rx_s2 <= 1'b1;
      st.rx_prev <= 1'b1;
      st.rstate <= R_IDLE;
      st.tstate <= T_IDLE;
      st.txd <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign O_WB_DAT = {24'h000000, st.rdat};
  assign O_WB_ACK = st.ack;
  assign O_TXD = st.txd;

  // checks
  tx_idle_high_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    st.tstate == T_IDLE |-> O_TXD) else $error("transmit line low while idle");
  tx_start_bit_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (wr && I_WB_ADR == ADR_DATA && mode_on) |=> !O_TXD && st.tstate == T_SEND)
    else $error("buffer write did not start a frame");
  tx_done_flag_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (st.tstate == T_SEND && tick && st.tcnt == OVS_LAST && st.tbits == 4'h2 && !wr)
    |=> st.ctrl[CTL_TI] && O_TXD) else $error("done flag not set at stop bit");
  rx_load_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (st.rstate == R_STOP && tick && st.rcnt == OVS_LAST && accept_now && !wr)
    |=> st.ctrl[CTL_RI] && st.rxbuf == $past(st.rshift[7:0]))
    else $error("accepted frame not loaded");
  rx_reject_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (st.rstate == R_STOP && tick && st.rcnt == OVS_LAST && !accept_now
     && !st.ctrl[CTL_RI] && !wr) |=> !st.ctrl[CTL_RI])
    else $error("rejected frame raised receive flag");
  fe_sticky_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (st.misc[MSC_FE] && !(wr && I_WB_ADR == ADR_MISC)) |=> st.misc[MSC_FE])
    else $error("framing error cleared by hardware");
  false_start_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (st.rstate == R_START && tick && st.rcnt == OVS_MID && rx) |=> st.rstate == R_IDLE)
    else $error("false start not abandoned");
  rx_rearm_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (st.rstate == R_STOP && tick && st.rcnt == OVS_LAST) |=> st.rstate == R_IDLE)
    else $error("receiver did not rearm");
  fixed_rate_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (fixed_mode && !dbl && tick) ##1 (fixed_mode && !dbl)[*3]
    |-> !$past(tick, 2) && !$past(tick) && !tick ##1 tick)
    else $error("fixed mode tick spacing wrong");
  rx_frame_c: cover property (@(posedge I_CLK) disable iff (I_RESET)
    st.rstate == R_STOP && tick && st.rcnt == OVS_LAST && accept_now);
  false_start_c: cover property (@(posedge I_CLK) disable iff (I_RESET)
    st.rstate == R_START && tick && st.rcnt == OVS_MID && rx);
  tx_done_c: cover property (@(posedge I_CLK) disable iff (I_RESET)
    st.tstate == T_SEND ##1 st.tstate == T_IDLE);
  fe_set_c: cover property (@(posedge I_CLK) disable iff (I_RESET) $rose(st.misc[MSC_FE]));
endmodule // asp_uart
`default_nettype wire

// ===== sim/asp_peer.sv
// remote serial peer: drives the receive line and captures transmit frames
`timescale 1ns/1ns
`default_nettype none
module asp_peer (
  // clock and lines
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd,
  // frame setup: bit period in clocks, ninth bit present
  input wire logic [15:0] i_per,
  input wire logic i_nine
);
  logic [7:0] rx_byte;
  logic rx_ninth;
  logic rx_stop;
  int rx_cnt = 0;
  // the line idles high, as a pulled-up serial line would
  initial o_rxd = 1'b1;
  // hold a level for n clocks
  task automatic hold(input logic v, input int n);
    o_rxd <= v;
    repeat (n) @(posedge i_clk);
  endtask
  // one frame lsb first; stop level is the caller's, so a broken frame can be sent
  task automatic send(input logic [7:0] d, input logic nb, input logic stp);
    hold(1'b0, i_per);
    for (int i = 0; i < 8; i++) hold(d[i], i_per);
    if (i_nine) hold(nb, i_per);
    hold(stp, i_per);
    hold(1'b1, 4);
  endtask
  // capture: sample each bit at its centre, timed from the start edge
  always begin
    @(negedge i_txd);
    repeat (i_per / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (i_per) @(posedge i_clk);
      rx_byte[i] = i_txd;
    end
    if (i_nine) begin
      repeat (i_per) @(posedge i_clk);
      rx_ninth = i_txd;
    end
    repeat (i_per) @(posedge i_clk);
    rx_stop = i_txd;
    rx_cnt++;
  end
endmodule // asp_peer
`default_nettype wire

// ===== sim/async_serial_port_modes_1_2_3_tb_top.sv
// testbench of the asynchronous serial port with a remote peer on the lines
`timescale 1ns/1ns
`default_nettype none
module async_serial_port_modes_1_2_3_tb_top;
  import asp_pkg::*;
  // one row: control, misc, timer 1 reload, data, ninth bit, bit period in clocks
  // no row loads an all-ones reload while doubling
  // the bench models no timer interrupt, so none is ever enabled
  // all rows are slow multiples of the clock, so no rate error arises
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] misc;
    logic [7:0] rl;
    logic [7:0] d;
    logic nb;
    logic [15:0] per;
  } asp_row_s;
  asp_row_s rows [5] = '{
    '{8'h98, 8'h00, 8'h00, 8'ha5, 1'b1, 16'd64},
    '{8'h90, 8'h01, 8'h00, 8'h3c, 1'b0, 16'd32},
    '{8'h50, 8'h0a, 8'hfc, 8'h81, 1'b1, 16'd128},
    '{8'hd8, 8'h0b, 8'hfc, 8'h00, 1'b1, 16'd64},
    '{8'h50, 8'h08, 8'hfe, 8'h6e, 1'b1, 16'd768}};
  logic [7:0] regs [9] = '{ADR_CTRL, ADR_DATA, ADR_MISC, ADR_T1RL, ADR_T3RL,
    ADR_T3RH, ADR_SLAVE_ADDRESS_REG, ADR_SLAVE_ADDRESS_MASK, ADR_TIMER3_AND_SERIAL_RATE_CONTROL};
  asp_row_s r;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic txd;
  logic rxd;
  logic [15:0] per = 16'd64;
  logic nine = 1'b0;
  logic [7:0] rq;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  int n0;
  // clock at 125 MHz
  always #4 clk = ~clk;
  asp_uart #(.IS_PORT1(1'b0)) u_dut (.I_CLK(clk), .I_RESET(rst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_RXD(rxd), .O_TXD(txd));
  asp_peer u_peer (.i_clk(clk), .i_txd(txd), .o_rxd(rxd), .i_per(per), .i_nine(nine));
  // compare and count
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // classic single cycle; read data taken at the edge that sees ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    check("bus ack", {7'h0, ack}, 8'h01);
    rq = rdat[7:0];
    check("upper zero", {7'h0, |rdat[31:8]}, 8'h00);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // bounded wait for the peer to capture a frame
  task automatic wait_rx(input int c);
    for (int n = 0; n < 40000 && u_peer.rx_cnt == c; n++) @(posedge clk);
  endtask
  // idle line and register reset values
  task automatic chk_reset;
    check("idle line", {7'h0, txd}, 8'h01);
    foreach (regs[i]) begin
      wb(1'b0, regs[i], 8'h00);
      check("reset value", rq, 8'h00);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard; the whole run needs a little over half of this
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    chk_reset();
    foreach (rows[k]) begin
      r = rows[k];
      per <= r.per;
      nine <= r.ctrl[CTL_SMH];
      wb(1'b1, ADR_MISC, r.misc);
      wb(1'b1, ADR_T1RL, r.rl);
      wb(1'b1, ADR_CTRL, r.ctrl);
      repeat (8 * r.per) @(posedge clk);
      n0 = u_peer.rx_cnt;
      wb(1'b1, ADR_DATA, r.d);
      wait_rx(n0);
      check("tx byte", u_peer.rx_byte, r.d);
      if (r.ctrl[CTL_SMH]) check("tx ninth", {7'h0, u_peer.rx_ninth}, {7'h0, r.nb});
      check("tx stop", {7'h0, u_peer.rx_stop}, 8'h01);
      wb(1'b0, ADR_CTRL, 8'h00);
      check("tx done", rq & 8'h02, 8'h02);
      wb(1'b1, ADR_CTRL, r.ctrl);
      u_peer.send(~r.d, r.nb, 1'b1);
      wb(1'b0, ADR_CTRL, 8'h00);
      check("rx flags", rq & 8'h05, {5'h0, r.nb, 2'b01});
      wb(1'b0, ADR_DATA, 8'h00);
      check("rx byte", rq, ~r.d);
    end
    // unmapped place reads zero and ignores writes
    wb(1'b1, 8'h40, 8'hff);
    wb(1'b0, 8'h40, 8'h00);
    check("unmapped", rq, 8'h00);
    // a full receive buffer refuses the next frame, then the next one is taken
    per <= 16'd32;
    nine <= 1'b1;
    wb(1'b1, ADR_MISC, 8'h01);
    wb(1'b1, ADR_CTRL, 8'h90);
    u_peer.send(8'h11, 1'b0, 1'b1);
    u_peer.send(8'h22, 1'b0, 1'b1);
    wb(1'b0, ADR_DATA, 8'h00);
    check("rx while full", rq, 8'h11);
    wb(1'b1, ADR_CTRL, 8'h90);
    u_peer.send(8'h33, 1'b0, 1'b1);
    wb(1'b0, ADR_DATA, 8'h00);
    check("rx resumed", rq, 8'h33);
    // address recognition under a mask: given 50, low nibble free
    wb(1'b1, ADR_SLAVE_ADDRESS_REG, 8'h5a);
    wb(1'b1, ADR_SLAVE_ADDRESS_MASK, 8'hf0);
    wb(1'b1, ADR_CTRL, 8'hb0);
    u_peer.send(8'h5a, 1'b0, 1'b1);
    u_peer.send(8'h12, 1'b1, 1'b1);
    wb(1'b0, ADR_CTRL, 8'h00);
    check("addr refused", rq, 8'hb0);
    u_peer.send(8'h5f, 1'b1, 1'b1);
    wb(1'b0, ADR_CTRL, 8'h00);
    check("addr taken", rq, 8'hb5);
    // framing error stays through a good frame until software clears it
    wb(1'b1, ADR_CTRL, 8'h90);
    u_peer.send(8'h44, 1'b0, 1'b0);
    wb(1'b1, ADR_CTRL, 8'h90);
    u_peer.send(8'h45, 1'b0, 1'b1);
    wb(1'b0, ADR_MISC, 8'h00);
    check("frame error", rq, 8'h05);
    wb(1'b1, ADR_MISC, 8'h01);
    wb(1'b0, ADR_MISC, 8'h00);
    check("error cleared", rq, 8'h01);
    // short low glitch is a false start; the frame after it is still received
    wb(1'b1, ADR_CTRL, 8'h90);
    u_peer.hold(1'b0, 6);
    u_peer.hold(1'b1, 40);
    u_peer.send(8'h5c, 1'b0, 1'b1);
    wb(1'b0, ADR_DATA, 8'h00);
    check("after glitch", rq, 8'h5c);
    // receiver disabled ignores the line
    wb(1'b1, ADR_CTRL, 8'h80);
    u_peer.send(8'h77, 1'b0, 1'b1);
    wb(1'b0, ADR_CTRL, 8'h00);
    check("rx disabled", rq, 8'h80);
    // synchronous mode is not built: a buffer write sends nothing
    wb(1'b1, ADR_CTRL, 8'h00);
    n0 = u_peer.rx_cnt;
    wb(1'b1, ADR_DATA, 8'h96);
    repeat (800) @(posedge clk);
    check("mode 00 quiet", 8'(u_peer.rx_cnt - n0), 8'h00);
    // stored control, then a second reset in mid-run
    wb(1'b1, ADR_TIMER3_AND_SERIAL_RATE_CONTROL, 8'h27);
    wb(1'b0, ADR_TIMER3_AND_SERIAL_RATE_CONTROL, 8'h00);
    check("rate control", rq, 8'h27);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_reset();
    print_verdict();
  end
endmodule // async_serial_port_modes_1_2_3_tb_top
`default_nettype wire
